// ---- rtl/nsif_pkg.sv ----
// constants for the status and interrupt flag block
package nsif_pkg;

    // number of flags held inside this block
    localparam int NSIF_NUM_FLAGS = 4;

    // position of each held flag in the internal flag vector
    localparam int NSIF_IDX_MEM_ERR   = 0;
    localparam int NSIF_IDX_RX_DONE   = 1;
    localparam int NSIF_IDX_TX_DONE   = 2;
    localparam int NSIF_IDX_INIT_DONE = 3;

    // number of event flags kept outside and only summarised here
    localparam int NSIF_NUM_EXT = 6;

    // position of each outside event in the outside event vector
    localparam int NSIF_EXT_BABBLE  = 0;
    localparam int NSIF_EXT_MISSED  = 1;
    localparam int NSIF_EXT_MISS_OVF  = 2;
    localparam int NSIF_EXT_RXCOL_OVF = 3;
    localparam int NSIF_EXT_JABBER  = 4;
    localparam int NSIF_EXT_TXSTART = 5;

    // vector types for held flags and outside events
    typedef logic [NSIF_NUM_FLAGS-1:0] nsif_flags_t;
    typedef logic [NSIF_NUM_EXT-1:0]   nsif_ext_t;

    // reset values
    localparam nsif_flags_t NSIF_FLAGS_RST = 4'h0;
    localparam logic        NSIF_BIT_RST   = 1'h0;

endpackage : nsif_pkg

// ---- rtl/nsif_top.sv ----
// status flags, summary interrupt and transmit demand logic
`timescale 1ns/10ps
// Operation
// - memory error flag set by bus logic; write one clears, zero keeps
// - memory error flag cleared by reset and by stop
// - receive-done set after frame received and last ring buffer handed back
// - receive-done drives irq only with global enable and receive mask clear
// - descriptor engine sets receive-done; write one clears, zero keeps
// - receive-done cleared by reset and by stop
// - transmit-done set after frame sent and last ring buffer handed back
// - transmit-done drives irq only with global enable and transmit mask clear
// - descriptor engine sets transmit-done; write one clears, zero keeps
// - transmit-done cleared by reset and by stop
// - init-done set when init block read; write one clears, zero ignored
// - init-done drives irq with global enable and init mask clear
// - init-done cleared by reset and by stop
// - summary flag is set while any unmasked event flag is active
// - transmit demand set by writing one; writing zero leaves it
// - descriptor fetch clears transmit demand
// - transmit demand cleared by reset and by stop
// - transmit demand requests ring access at once, not waiting for poll
// - transmitter off clears transmit demand and blocks ring access
module nsif_top
(
    input  wire logic clk,                         // system clock, 100 MHz
    input  wire logic rst_n,                       // async reset, active low
    input  wire logic csr_write,                   // software status write pulse
    input  wire logic wr_memory_error,             // written value, memory error
    input  wire logic wr_receive_done,             // written value, receive done
    input  wire logic wr_transmit_done,            // written value, transmit done
    input  wire logic wr_init_done,                // written value, init done
    input  wire logic wr_transmit_demand,          // written value, demand
    input  wire logic stop_set,                    // software sets stop, pulse
    input  wire logic bus_mem_error,               // bus unit memory error pulse
    input  wire logic rx_last_buffer_done,         // last rx buffer handed back
    input  wire logic tx_last_buffer_done,         // last tx buffer handed back
    input  wire logic init_block_read,             // init block read complete
    input  wire logic tx_desc_fetch,               // engine fetches tx descriptor
    input  wire logic poll_tick,                   // poll interval elapsed pulse
    input  wire logic transmitter_on,              // transmitter enabled level
    input  wire logic auto_poll_disable,           // automatic polling disabled
    input  wire logic global_interrupt_enable,     // global irq enable
    input  wire logic memory_error_mask,           // mask for memory error
    input  wire logic receive_done_mask,           // mask for receive done
    input  wire logic transmit_done_mask,          // mask for transmit done
    input  wire logic init_done_mask,              // mask for init done
    input  wire nsif_pkg::nsif_ext_t ext_flags,    // outside event flags
    input  wire nsif_pkg::nsif_ext_t ext_masks,    // masks for outside events
    output logic      memory_error_flag,           // registered flag
    output logic      receive_done_flag,           // registered flag
    output logic      transmit_done_flag,          // registered flag
    output logic      init_done_flag,              // registered flag
    output logic      summary_interrupt_flag,      // registered summary
    output logic      transmit_demand,             // registered demand bit
    output logic      tx_ring_request,             // registered ring access req
    output logic      irq                          // registered interrupt request
);
    import nsif_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // held flags
    ////////////////////////////////////////////////////////////////////////

    nsif_flags_t flag_q;
    nsif_flags_t flag_d;
    nsif_flags_t flag_set;
    nsif_flags_t flag_wr1;
    nsif_flags_t flag_mask;
    logic        summary_q;
    logic        summary_d;
    logic        irq_q;
    logic        demand_q;
    logic        demand_d;
    logic        ring_req_q;
    logic        ring_req_d;
    logic        demand_wr1;

    // hardware set sources, one per held flag
    always_comb
    begin
        flag_set                     = NSIF_FLAGS_RST;
        flag_set[NSIF_IDX_MEM_ERR]   = bus_mem_error;
        flag_set[NSIF_IDX_RX_DONE]   = rx_last_buffer_done;
        flag_set[NSIF_IDX_TX_DONE]   = tx_last_buffer_done;
        flag_set[NSIF_IDX_INIT_DONE] = init_block_read;
    end

    // write-one-to-clear requests from software
    always_comb
    begin
        flag_wr1                     = NSIF_FLAGS_RST;
        flag_wr1[NSIF_IDX_MEM_ERR]   = csr_write & wr_memory_error;
        flag_wr1[NSIF_IDX_RX_DONE]   = csr_write & wr_receive_done;
        flag_wr1[NSIF_IDX_TX_DONE]   = csr_write & wr_transmit_done;
        flag_wr1[NSIF_IDX_INIT_DONE] = csr_write & wr_init_done;
    end

    // masks that keep each held flag out of the summary
    always_comb
    begin
        flag_mask                     = NSIF_FLAGS_RST;
        flag_mask[NSIF_IDX_MEM_ERR]   = memory_error_mask;
        flag_mask[NSIF_IDX_RX_DONE]   = receive_done_mask;
        flag_mask[NSIF_IDX_TX_DONE]   = transmit_done_mask;
        flag_mask[NSIF_IDX_INIT_DONE] = init_done_mask;
    end

    // per flag: stop clears first, a set beats a same-cycle write clear
    genvar gi;
    generate
        for (gi = 0; gi < NSIF_NUM_FLAGS; gi++)
        begin : g_flag
            always_comb
            begin
                if (stop_set)
                    flag_d[gi] = 1'h0;
                else if (flag_set[gi])
                    flag_d[gi] = 1'h1;
                else if (flag_wr1[gi])
                    flag_d[gi] = 1'h0;
                else
                    flag_d[gi] = flag_q[gi];
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    flag_q[gi] <= NSIF_BIT_RST;
                else
                    flag_q[gi] <= flag_d[gi];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // summary flag and interrupt request
    ////////////////////////////////////////////////////////////////////////

    // summary follows the next flag values so it moves with them
    assign summary_d = (|(flag_d & ~flag_mask))
                     | (|(ext_flags & ~ext_masks));

    // summary register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            summary_q <= NSIF_BIT_RST;
        else
            summary_q <= summary_d;
    end

    // request raised only for unmasked events under global enable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_q <= NSIF_BIT_RST;
        else
            irq_q <= global_interrupt_enable & summary_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit demand and ring access request
    ////////////////////////////////////////////////////////////////////////

    assign demand_wr1 = csr_write & wr_transmit_demand;

    // demand: stop or transmitter off clear, write one beats fetch clear
    always_comb
    begin
        if (stop_set || !transmitter_on)
            demand_d = 1'h0;
        else if (demand_wr1)
            demand_d = 1'h1;
        else if (tx_desc_fetch)
            demand_d = 1'h0;
        else
            demand_d = demand_q;
    end

    // demand register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            demand_q <= NSIF_BIT_RST;
        else
            demand_q <= demand_d;
    end

    // ring request: demand asks at once, poll tick only when polling on
    always_comb
    begin
        if (stop_set || !transmitter_on || tx_desc_fetch)
            ring_req_d = 1'h0;
        else if (demand_q)
            ring_req_d = 1'h1;
        else if (poll_tick && !auto_poll_disable)
            ring_req_d = 1'h1;
        else
            ring_req_d = ring_req_q;
    end

    // ring request register, held until the fetch, a stop or transmitter off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ring_req_q <= NSIF_BIT_RST;
        else
            ring_req_q <= ring_req_d;
    end

    // outputs straight from the registers
    assign memory_error_flag      = flag_q[NSIF_IDX_MEM_ERR];
    assign receive_done_flag      = flag_q[NSIF_IDX_RX_DONE];
    assign transmit_done_flag     = flag_q[NSIF_IDX_TX_DONE];
    assign init_done_flag         = flag_q[NSIF_IDX_INIT_DONE];
    assign summary_interrupt_flag = summary_q;
    assign transmit_demand        = demand_q;
    assign tx_ring_request        = ring_req_q;
    assign irq                    = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!rst_n);

    // memory error set by the bus unit
    a_mem_err_set: assert property (
        bus_mem_error && !stop_set |=> memory_error_flag)
        else $error("memory error flag not set by bus error");

    // write one clears memory error unless a new error arrives
    a_mem_err_clear: assert property (
        csr_write && wr_memory_error && !bus_mem_error && !stop_set
        |=> !memory_error_flag)
        else $error("memory error flag not cleared by write one");

    // write zero keeps the receive done flag
    a_wr0_keeps: assert property (
        csr_write && !wr_receive_done && !stop_set && receive_done_flag
        |=> receive_done_flag)
        else $error("receive done flag lost on write zero");

    // stop clears all held flags and the demand bit together
    a_stop_clears: assert property (
        stop_set |=> !memory_error_flag && !receive_done_flag
            && !transmit_done_flag && !init_done_flag
            && !transmit_demand && !tx_ring_request)
        else $error("stop did not clear flags");

    // receive done set wins over a same-cycle clear
    a_rx_set_wins: assert property (
        rx_last_buffer_done && !stop_set |=> receive_done_flag)
        else $error("receive done flag not set");

    // transmit done set and held until cleared
    a_tx_set_hold: assert property (
        tx_last_buffer_done && !stop_set
        ##1 (!stop_set && !(csr_write && wr_transmit_done))[*2]
        |-> transmit_done_flag)
        else $error("transmit done flag not held");

    // init done set by the init block read
    a_init_set: assert property (
        init_block_read && !stop_set |=> init_done_flag)
        else $error("init done flag not set");

    // unmasked receive done raises the request under global enable
    a_irq_rx: assert property (
        receive_done_flag && $past(global_interrupt_enable)
        && !$past(receive_done_mask) |-> irq)
        else $error("irq missing for receive done");

    // unmasked transmit done raises the request under global enable
    a_irq_tx: assert property (
        transmit_done_flag && $past(global_interrupt_enable)
        && !$past(transmit_done_mask) |-> irq)
        else $error("irq missing for transmit done");

    // unmasked init done raises the request under global enable
    a_irq_init: assert property (
        init_done_flag && $past(global_interrupt_enable)
        && !$past(init_done_mask) |-> irq)
        else $error("irq missing for init done");

    // no request without global enable and a summary
    a_irq_gated: assert property (
        irq |-> $past(global_interrupt_enable) && summary_interrupt_flag)
        else $error("irq without enable or summary");

    // unmasked outside event shows in the summary one cycle later
    a_sum_ext: assert property (
        |(ext_flags & ~ext_masks) |=> summary_interrupt_flag)
        else $error("summary missed an outside event");

    // stop with every outside event masked or idle leaves the summary clear
    a_sum_masked: assert property (
        !(|(ext_flags & ~ext_masks)) && stop_set |=> !summary_interrupt_flag)
        else $error("summary set with nothing unmasked");

    // write one sets the demand while the transmitter is on
    a_demand_set: assert property (
        csr_write && wr_transmit_demand && transmitter_on && !stop_set
        |=> transmit_demand)
        else $error("transmit demand not set by write one");

    // descriptor fetch clears demand unless rewritten
    a_demand_fetch: assert property (
        tx_desc_fetch && !(csr_write && wr_transmit_demand)
        |=> !transmit_demand)
        else $error("transmit demand not cleared by fetch");

    // demand asks for the ring at once
    a_demand_req: assert property (
        transmit_demand && transmitter_on && !stop_set && !tx_desc_fetch
        |=> tx_ring_request)
        else $error("demand did not request ring access");

    // transmitter off kills demand and ring access
    a_txoff_idle: assert property (
        !transmitter_on |=> !transmit_demand && !tx_ring_request)
        else $error("ring access with transmitter off");

    // with polling disabled a tick alone requests nothing
    a_no_auto_poll: assert property (
        !tx_ring_request && !transmit_demand && poll_tick
        && auto_poll_disable |=> !tx_ring_request)
        else $error("poll tick requested ring with polling off");

    // covers for the main scenarios
    c_rx_irq: cover property (
        rx_last_buffer_done ##1 receive_done_flag ##[1:4] irq);

    c_set_clear_same: cover property (
        tx_last_buffer_done && csr_write && wr_transmit_done);

    c_demand_fetch: cover property (
        transmit_demand ##1 tx_ring_request ##[1:8] tx_desc_fetch);

    c_stop_all: cover property (
        memory_error_flag && init_done_flag && stop_set);

endmodule : nsif_top

// ---- bench/nsif_tb.sv ----
// self-checking testbench for the status and interrupt flag block
`timescale 1ns/10ps
module testbench;
    import nsif_pkg::*;

    logic        clk;                  // system clock
    logic        rst_n;                // reset, active low
    logic        csr_write;            // status write pulse
    logic        wr_transmit_demand;   // written demand bit
    logic        stop_set;             // stop pulse
    logic        tx_desc_fetch;        // descriptor fetch pulse
    logic        poll_tick;            // poll interval pulse
    logic        transmitter_on;       // transmitter enable level
    logic        auto_poll_disable;    // automatic poll off
    logic        global_interrupt_enable; // irq enable
    nsif_flags_t hset;                 // set events, flag order
    nsif_flags_t hwr;                  // written clear bits, flag order
    nsif_flags_t hmask;                // held flag masks
    nsif_ext_t   ext_flags;            // outside events
    nsif_ext_t   ext_masks;            // outside masks
    wire nsif_flags_t flg;             // held flag outputs
    wire         summary;              // summary flag
    wire         demand;               // transmit demand
    wire         ring_req;             // ring access request
    wire         irq;                  // interrupt request
    int          errors;               // mismatches
    int          cmp_count;            // comparisons

    nsif_top nsif_top_i (
        .clk(clk), .rst_n(rst_n), .csr_write(csr_write),
        .wr_memory_error(hwr[NSIF_IDX_MEM_ERR]), .wr_receive_done(hwr[NSIF_IDX_RX_DONE]),
        .wr_transmit_done(hwr[NSIF_IDX_TX_DONE]), .wr_init_done(hwr[NSIF_IDX_INIT_DONE]),
        .wr_transmit_demand(wr_transmit_demand), .stop_set(stop_set),
        .bus_mem_error(hset[NSIF_IDX_MEM_ERR]), .rx_last_buffer_done(hset[NSIF_IDX_RX_DONE]),
        .tx_last_buffer_done(hset[NSIF_IDX_TX_DONE]),
        .init_block_read(hset[NSIF_IDX_INIT_DONE]), .tx_desc_fetch(tx_desc_fetch),
        .poll_tick(poll_tick), .transmitter_on(transmitter_on),
        .auto_poll_disable(auto_poll_disable),
        .global_interrupt_enable(global_interrupt_enable),
        .memory_error_mask(hmask[NSIF_IDX_MEM_ERR]), .receive_done_mask(hmask[NSIF_IDX_RX_DONE]),
        .transmit_done_mask(hmask[NSIF_IDX_TX_DONE]),
        .init_done_mask(hmask[NSIF_IDX_INIT_DONE]), .ext_flags(ext_flags),
        .ext_masks(ext_masks), .memory_error_flag(flg[NSIF_IDX_MEM_ERR]),
        .receive_done_flag(flg[NSIF_IDX_RX_DONE]), .transmit_done_flag(flg[NSIF_IDX_TX_DONE]),
        .init_done_flag(flg[NSIF_IDX_INIT_DONE]), .summary_interrupt_flag(summary),
        .transmit_demand(demand), .tx_ring_request(ring_req), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // one cycle: rising edge lands, inputs change at falling edge
    task tick;
        @(negedge clk);
    endtask : tick

    // compare seen against expected
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task end_sim;
        $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    // all outputs low after reset
    task t_reset;
        chk({flg, summary, demand, ring_req, irq}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    // each held flag: set, write zero keeps, set beats clear, write one clears
    task t_flags;
        for (int i = 0; i < NSIF_NUM_FLAGS; i++)
        begin
            hset[i] = 1'b1;
            tick;
            hset = 4'h0;
            chk(flg, 4'h1 << i);
            chk({summary, irq}, 2'h3);
            csr_write = 1'b1;
            hwr = ~(4'h1 << i);
            tick;
            chk(flg, 4'h1 << i);
            hwr = 4'h1 << i;
            hset[i] = 1'b1;
            tick;
            hset = 4'h0;
            chk(flg, 4'h1 << i);
            tick;
            csr_write = 1'b0;
            hwr = 4'h0;
            chk({flg, summary, irq}, 6'h00);
        end
        $display("test flags done");
    endtask : t_flags

    // masked flag stays out of summary; enable gates irq
    task t_masks;
        for (int i = 0; i < NSIF_NUM_FLAGS; i++)
        begin
            hmask = 4'h1 << i;
            hset[i] = 1'b1;
            tick;
            hset = 4'h0;
            chk({flg[i], summary, irq}, 3'h4);
            global_interrupt_enable = 1'b0;
            hmask = 4'h0;
            tick;
            chk({summary, irq}, 2'h2);
            global_interrupt_enable = 1'b1;
            csr_write = 1'b1;
            hwr = 4'hF;
            tick;
            csr_write = 1'b0;
            hwr = 4'h0;
            chk({flg, summary, irq}, 6'h00);
        end
        $display("test masks done");
    endtask : t_masks

    // every outside event reaches summary unless its own mask is set
    task t_ext;
        for (int i = 0; i < NSIF_NUM_EXT; i++)
        begin
            ext_flags = 6'h01 << i;
            ext_masks = ~(6'h01 << i);
            tick;
            chk({summary, irq}, 2'h3);
            ext_masks = 6'h01 << i;
            tick;
            chk({summary, irq}, 2'h0);
            ext_flags = 6'h00;
            ext_masks = 6'h00;
        end
        $display("test ext done");
    endtask : t_ext

    // stop clears every flag and demand, and beats a same-cycle set
    task t_stop;
        transmitter_on = 1'b1;
        hset = 4'hF;
        csr_write = 1'b1;
        wr_transmit_demand = 1'b1;
        tick;
        hset = 4'h0;
        csr_write = 1'b0;
        wr_transmit_demand = 1'b0;
        chk({flg, demand}, 5'h1F);
        stop_set = 1'b1;
        tick;
        chk({flg, summary, demand, ring_req, irq}, 8'h00);
        hset = 4'hF;
        tick;
        stop_set = 1'b0;
        hset = 4'h0;
        chk({flg, summary, irq}, 6'h00);
        $display("test stop done");
    endtask : t_stop

    // demand write, ring request, fetch, transmitter off, poll path
    task t_demand;
        auto_poll_disable = 1'b1;
        csr_write = 1'b1;
        tick;
        chk(demand, 1'b0);
        wr_transmit_demand = 1'b1;
        tick;
        csr_write = 1'b0;
        wr_transmit_demand = 1'b0;
        chk({demand, ring_req}, 2'h2);
        tick;
        chk({demand, ring_req}, 2'h3);
        tx_desc_fetch = 1'b1;
        tick;
        tx_desc_fetch = 1'b0;
        chk({demand, ring_req}, 2'h0);
        transmitter_on = 1'b0;
        csr_write = 1'b1;
        wr_transmit_demand = 1'b1;
        tick;
        chk({demand, ring_req}, 2'h0);
        transmitter_on = 1'b1;
        tick;
        csr_write = 1'b0;
        wr_transmit_demand = 1'b0;
        chk(demand, 1'b1);
        transmitter_on = 1'b0;
        tick;
        chk({demand, ring_req}, 2'h0);
        transmitter_on = 1'b1;
        poll_tick = 1'b1;
        tick;
        poll_tick = 1'b0;
        tick;
        chk(ring_req, 1'b0);
        auto_poll_disable = 1'b0;
        poll_tick = 1'b1;
        tick;
        poll_tick = 1'b0;
        chk(ring_req, 1'b1);
        tx_desc_fetch = 1'b1;
        tick;
        tx_desc_fetch = 1'b0;
        chk(ring_req, 1'b0);
        $display("test demand done");
    endtask : t_demand

    ////////////////////////////////////////////////////////////////////////////
    // watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        errors = errors + 1;
        end_sim;
    end

    // main sequence
    initial
    begin
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        csr_write = 1'b0;
        wr_transmit_demand = 1'b0;
        stop_set = 1'b0;
        tx_desc_fetch = 1'b0;
        poll_tick = 1'b0;
        transmitter_on = 1'b0;
        auto_poll_disable = 1'b1;
        global_interrupt_enable = 1'b1;
        hset = 4'h0;
        hwr = 4'h0;
        hmask = 4'h0;
        ext_flags = 6'h00;
        ext_masks = 6'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        tick;
        t_reset;
        t_flags;
        t_masks;
        t_ext;
        t_stop;
        t_demand;
        end_sim;
    end
endmodule : testbench
